// ===== perf_block.sv
// Receive performance block: interrupt masks, line and path violation counters.
// Assumes the framer supplies one-cycle error pulses and level status flags on clk_sys.
`timescale 1ns/1ps

module perf_block
    import perf_pkg::*;
#(
    parameter int unsigned LONG_CYCLES  = LONG_INTERVAL_CYCLES,
    parameter int unsigned SHORT_CYCLES = SHORT_INTERVAL_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic [7:0] status1_flags,
    input  wire logic [7:0] status2_flags,
    input  wire logic       interval_select,
    input  wire logic       rx_zero_sub_enable,
    input  wire logic       rx_framing_select,
    input  wire logic       excess_zero_count_enable,
    input  wire logic       fs_error_count_enable,
    input  wire logic       rx_sync_lost,
    input  wire logic       bpv_pulse,
    input  wire logic       bpv_in_codeword,
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit_zero,
    input  wire logic       crc6_error,
    input  wire logic       ft_error,
    input  wire logic       fs_error,
    input  wire logic [3:0] mos_nibble,
    output logic            interval_tick,
    output logic            irq
);
    logic [7:0]         status1_irq_mask_r;
    logic [7:0]         status2_irq_mask_r;
    logic [7:0]         rd_data_r;
    logic [7:0]         rd_data_nxt;
    logic               irq_r;
    logic [7:0]         hit1;
    logic [7:0]         hit2;
    logic [TIMER_W-1:0] timer_r;
    logic [TIMER_W-1:0] timer_last;
    logic               tick_r;
    logic [4:0]         zero_run_r;
    logic [4:0]         zero_limit;
    logic               zero_evt;
    logic               bpv_counted;
    logic [1:0]         line_amt;
    logic [1:0]         path_amt;

    viol_cnt_if #(.W(LINE_W)) line_cnt ();
    viol_cnt_if #(.W(PATH_W)) path_cnt ();

    if (LONG_CYCLES < 2 || SHORT_CYCLES < 2 || LONG_CYCLES >= (1 << TIMER_W)
        || SHORT_CYCLES >= (1 << TIMER_W)) begin : g_check
        $error("perf_block interval counts out of range");
    end

    // ----------------------------------------------------------------
    // Mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status1_irq_mask_r <= MASK_RESET;
        end else if (wr_en && addr == ADDR_MASK1) begin
            status1_irq_mask_r <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status2_irq_mask_r <= MASK_RESET;
        end else if (wr_en && addr == ADDR_MASK2) begin
            status2_irq_mask_r <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_hit
        assign hit1[i] = status1_flags[i] & status1_irq_mask_r[i];
        assign hit2[i] = status2_flags[i] & status2_irq_mask_r[i];
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (|hit1) | (|hit2);
        end
    end

    assign irq = irq_r;

    // ----------------------------------------------------------------
    // Interval timer
    // ----------------------------------------------------------------
    // A select change mid-interval can leave the count past the short
    // limit, so the compare is >= and the interval ends at once.
    assign timer_last = interval_select ? TIMER_W'(SHORT_CYCLES - 1)
                                        : TIMER_W'(LONG_CYCLES - 1);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            timer_r <= '0;
            tick_r  <= 1'b0;
        end else if (timer_r >= timer_last) begin
            timer_r <= '0;
            tick_r  <= 1'b1;
        end else begin
            timer_r <= timer_r + TIMER_W'(1);
            tick_r  <= 1'b0;
        end
    end

    assign interval_tick     = tick_r;
    assign line_cnt.boundary = tick_r;
    assign path_cnt.boundary = tick_r;

    // ----------------------------------------------------------------
    // Line violation sources
    // ----------------------------------------------------------------
    always_comb begin
        if (rx_zero_sub_enable && excess_zero_count_enable) begin
            zero_limit = ZERO_RUN_SHORT;
        end else begin
            zero_limit = ZERO_RUN_LONG;
        end
    end

    // Zero-run events are suppressed only in substitution-without-count mode
    assign zero_evt = rx_bit_valid && rx_bit_zero && (zero_run_r == zero_limit - 5'h01)
                      && !(rx_zero_sub_enable && !excess_zero_count_enable);

    // The run counter parks at its limit so one long run counts once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            zero_run_r <= 5'h00;
        end else if (rx_bit_valid && !rx_bit_zero) begin
            zero_run_r <= 5'h00;
        end else if (rx_bit_valid && zero_run_r < zero_limit) begin
            zero_run_r <= zero_run_r + 5'h01;
        end else if (zero_run_r > zero_limit) begin
            zero_run_r <= zero_limit;
        end
    end

    assign bpv_counted = bpv_pulse && !(rx_zero_sub_enable && bpv_in_codeword);

    // No sync qualifier here: line errors count through loss of frame
    assign line_amt     = {1'b0, bpv_counted} + {1'b0, zero_evt};
    assign line_cnt.amt = line_amt;

    // ----------------------------------------------------------------
    // Path violation sources
    // ----------------------------------------------------------------
    always_comb begin
        if (rx_sync_lost) begin
            path_amt = 2'h0;
        end else if (rx_framing_select) begin
            path_amt = {1'b0, crc6_error};
        end else begin
            path_amt = {1'b0, ft_error}
                     + {1'b0, fs_error & fs_error_count_enable};
        end
    end

    assign path_cnt.amt = path_amt;

    viol_counter #(.W(LINE_W)) u_line (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .cnt     (line_cnt.counter)
    );

    viol_counter #(.W(PATH_W)) u_path (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .cnt     (path_cnt.counter)
    );

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        case (addr)
            ADDR_LINE_HI: rd_data_nxt = line_cnt.latched[15:8];
            ADDR_LINE_LO: rd_data_nxt = line_cnt.latched[7:0];
            ADDR_PATH_HI: rd_data_nxt = {mos_nibble, path_cnt.latched[11:8]};
            ADDR_PATH_LO: rd_data_nxt = path_cnt.latched[7:0];
            ADDR_MASK2:   rd_data_nxt = status2_irq_mask_r;
            ADDR_MASK1:   rd_data_nxt = status1_irq_mask_r;
            default:      rd_data_nxt = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_r <= READ_UNMAPPED;
        end else if (rd_en) begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_mask1_write;
        wr_en && addr == ADDR_MASK1 |=> status1_irq_mask_r == $past(wr_data);
    endproperty
    a_mask1_write: assert property (p_mask1_write)
        else $error("mask1 write not stored");

    property p_mask2_read;
        wr_en && addr == ADDR_MASK2 ##1 rd_en && addr == ADDR_MASK2 && !wr_en
            |=> rd_data == $past(wr_data, 2);
    endproperty
    a_mask2_read: assert property (p_mask2_read)
        else $error("mask2 readback mismatch");

    property p_irq;
        ((|(status1_flags & status1_irq_mask_r)) || (|(status2_flags & status2_irq_mask_r)))
            |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled flag without interrupt");

    property p_irq_quiet;
        (status1_flags & status1_irq_mask_r) == 8'h00
            && (status2_flags & status2_irq_mask_r) == 8'h00 |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt without enabled flag");

    property p_latch;
        tick_r |=> line_cnt.latched == $past(line_cnt.count)
                   && path_cnt.latched == $past(path_cnt.count);
    endproperty
    a_latch: assert property (p_latch)
        else $error("counters not latched at boundary");

    property p_tick_short;
        interval_select && tick_r ##1 interval_select [*8] |-> !tick_r;
    endproperty
    a_tick_short: assert property (p_tick_short)
        else $error("short interval ended early");

    property p_stable;
        !tick_r |=> $stable(line_cnt.latched) && $stable(path_cnt.latched);
    endproperty
    a_stable: assert property (p_stable)
        else $error("latched count moved mid interval");

    property p_saturate;
        line_cnt.count == 16'hFFFF && !tick_r |=> line_cnt.count == 16'hFFFF;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("line counter wrapped");

    property p_line_hi_read;
        rd_en && addr == ADDR_LINE_HI |=> rd_data == $past(line_cnt.latched[15:8]);
    endproperty
    a_line_hi_read: assert property (p_line_hi_read)
        else $error("line high byte read wrong");

    property p_line_in_los;
        rx_sync_lost && bpv_pulse && !rx_zero_sub_enable && !tick_r
            && line_cnt.count < 16'hFFF0 |=> line_cnt.count > $past(line_cnt.count);
    endproperty
    a_line_in_los: assert property (p_line_in_los)
        else $error("line counter stalled in sync loss");

    property p_zero16;
        !rx_zero_sub_enable && rx_bit_valid && rx_bit_zero && zero_run_r == 5'h0F
            |-> line_amt == {1'b0, bpv_counted} + 2'h1;
    endproperty
    a_zero16: assert property (p_zero16)
        else $error("16 zero run not counted");

    property p_codeword;
        rx_zero_sub_enable && !excess_zero_count_enable && bpv_in_codeword |-> line_amt == 2'h0;
    endproperty
    a_codeword: assert property (p_codeword)
        else $error("substitution code word counted");

    property p_zero8;
        rx_zero_sub_enable && excess_zero_count_enable && rx_bit_valid && rx_bit_zero
            && zero_run_r == 5'h07 && !bpv_pulse |-> line_amt == 2'h1;
    endproperty
    a_zero8: assert property (p_zero8)
        else $error("8 zero run not counted");

    property p_path_hi_read;
        rd_en && addr == ADDR_PATH_HI
            |=> rd_data == {$past(mos_nibble), $past(path_cnt.latched[11:8])};
    endproperty
    a_path_hi_read: assert property (p_path_hi_read)
        else $error("path high byte read wrong");

    property p_esf;
        !rx_sync_lost && rx_framing_select |-> path_amt == {1'b0, crc6_error};
    endproperty
    a_esf: assert property (p_esf)
        else $error("ESF path source wrong");

    property p_d4_fs;
        !rx_sync_lost && !rx_framing_select && fs_error_count_enable && ft_error && fs_error
            |-> path_amt == 2'h2;
    endproperty
    a_d4_fs: assert property (p_d4_fs)
        else $error("D4 Ft plus Fs not counted");

    property p_path_los;
        rx_sync_lost && !tick_r |=> path_cnt.count == $past(path_cnt.count);
    endproperty
    a_path_los: assert property (p_path_los)
        else $error("path counted during sync loss");

    c_boundary:   cover property (tick_r && line_cnt.count != 16'h0000);
    c_line_sat:   cover property (line_cnt.count == 16'hFFFF);
    c_irq:        cover property (!irq ##1 irq);
    c_path_count: cover property (path_amt != 2'h0 ##1 rd_en && addr == ADDR_PATH_LO);
endmodule

// ===== perf_pkg.sv
// Constants for the receive performance block: mask registers, error counters, interval timer.
// Assumes a single 10 MHz system clock and an 8-bit parallel register port.

package perf_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_LINE_HI  = 8'h23;
    localparam logic [7:0] ADDR_LINE_LO  = 8'h24;
    localparam logic [7:0] ADDR_PATH_HI  = 8'h25;
    localparam logic [7:0] ADDR_PATH_LO  = 8'h26;
    localparam logic [7:0] ADDR_MASK2    = 8'h6F;
    localparam logic [7:0] ADDR_MASK1    = 8'h7F;

    // ----------------------------------------------------------------
    // Reset values, widths and zero-run limits
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int         LINE_W        = 16;
    localparam int         PATH_W        = 12;
    localparam logic [4:0] ZERO_RUN_LONG  = 5'h10;
    localparam logic [4:0] ZERO_RUN_SHORT = 5'h08;

    // ----------------------------------------------------------------
    // Interval timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ               = 10_000_000;
    localparam int LONG_INTERVAL_MS     = 1000;
    localparam int SHORT_INTERVAL_MS    = 42;
    localparam int LONG_INTERVAL_CYCLES = (CLK_HZ / 1000) * LONG_INTERVAL_MS;
    localparam int SHORT_INTERVAL_CYCLES = (CLK_HZ / 1000) * SHORT_INTERVAL_MS;
    localparam int TIMER_W              = 24;

endpackage

// ===== test_perf_block.sv
// Self-checking bench for the receive performance block: masks, interrupt, violation counters.
// Assumes perf_pkg and the design files are compiled first; inputs change on falling edges.
`timescale 1ns/1ps

module test_perf_block;
    import perf_pkg::*;

    // ----------------------------------------------------------------
    // Short intervals keep the run small; saturation uses the long one
    // ----------------------------------------------------------------
    localparam int unsigned LONG_C  = 4400;
    localparam int unsigned SHORT_C = 40;

    logic       clk_sys;
    logic       arst_n;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic [7:0] status1_flags;
    logic [7:0] status2_flags;
    logic       interval_select;
    logic       rx_zero_sub_enable;
    logic       rx_framing_select;
    logic       excess_zero_count_enable;
    logic       fs_error_count_enable;
    logic       rx_sync_lost;
    logic       bpv_pulse;
    logic       bpv_in_codeword;
    logic       rx_bit_valid;
    logic       rx_bit_zero;
    logic       crc6_error;
    logic       ft_error;
    logic       fs_error;
    logic [3:0] mos_nibble;
    logic       interval_tick;
    logic       irq;
    int         error_cnt;
    int         compares;
    int         cyc;
    int         tick_at = 0;
    int         tick_gap = 0;

    perf_block #(.LONG_CYCLES(LONG_C), .SHORT_CYCLES(SHORT_C)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .status1_flags(status1_flags), .status2_flags(status2_flags),
        .interval_select(interval_select), .rx_zero_sub_enable(rx_zero_sub_enable),
        .rx_framing_select(rx_framing_select),
        .excess_zero_count_enable(excess_zero_count_enable),
        .fs_error_count_enable(fs_error_count_enable), .rx_sync_lost(rx_sync_lost),
        .bpv_pulse(bpv_pulse), .bpv_in_codeword(bpv_in_codeword),
        .rx_bit_valid(rx_bit_valid), .rx_bit_zero(rx_bit_zero),
        .crc6_error(crc6_error), .ft_error(ft_error), .fs_error(fs_error),
        .mos_nibble(mos_nibble), .interval_tick(interval_tick), .irq(irq));

    // ----------------------------------------------------------------
    // Clock, hang guard, checking
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 25000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // Gap between the last two boundaries, in clock cycles
    always @(negedge clk_sys) begin
        if (interval_tick === 1'b1) begin
            tick_gap <= cyc - tick_at;
            tick_at  <= cyc;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // Register port and event drivers, entered on a falling edge
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wr_data = d; wr_en = 1'b1;
        @(negedge clk_sys);
        wr_en = 1'b0;
    endtask

    // rd_data holds until the next read, so an extra cycle costs nothing
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        addr = a; rd_en = 1'b1;
        @(negedge clk_sys);
        rd_en = 1'b0;
        @(negedge clk_sys);
        chk(nm, {8'h00, rd_data}, {8'h00, e});
    endtask

    // Order of v: bpv, codeword, crc6, ft, fs
    task automatic ev(input logic [4:0] v);
        {bpv_pulse, bpv_in_codeword, crc6_error, ft_error, fs_error} = v;
        @(negedge clk_sys);
        {bpv_pulse, bpv_in_codeword, crc6_error, ft_error, fs_error} = 5'h00;
        @(negedge clk_sys);
    endtask

    task automatic bits(input int n, input logic z);
        rx_bit_valid = 1'b1; rx_bit_zero = z;
        repeat (n) @(negedge clk_sys);
        rx_bit_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic sync_tick(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (interval_tick !== 1'b1 && n < 5000);
    endtask

    // Order of m: zero sub, zero-run count, framing, fs count
    task automatic mode(input logic [3:0] m);
        int n;
        {rx_zero_sub_enable, excess_zero_count_enable, rx_framing_select,
         fs_error_count_enable} = m;
        sync_tick(n);
    endtask

    task automatic counts(input logic [15:0] el, input logic [11:0] ep, input int gap);
        int n;
        sync_tick(n);
        @(negedge clk_sys);
        chk("tick_seen", {15'h0000, n < 5000}, 16'h0001);
        chk("tick_gap", 16'(tick_gap), 16'(gap));
        rdchk(ADDR_LINE_HI, el[15:8], "line_hi");
        rdchk(ADDR_LINE_LO, el[7:0], "line_lo");
        rdchk(ADDR_PATH_HI, {mos_nibble, ep[11:8]}, "path_hi");
        rdchk(ADDR_PATH_LO, ep[7:0], "path_lo");
        repeat (3) ev(5'b10000);
        rdchk(ADDR_LINE_LO, el[7:0], "line_lo_held");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        error_cnt = 0; compares = 0; cyc = 0;
        arst_n = 1'b0; addr = 8'h00; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
        status1_flags = 8'h00; status2_flags = 8'h00; interval_select = 1'b1;
        {rx_zero_sub_enable, excess_zero_count_enable} = 2'b00;
        {rx_framing_select, fs_error_count_enable, rx_sync_lost} = 3'b000;
        {bpv_pulse, bpv_in_codeword, crc6_error, ft_error, fs_error} = 5'h00;
        rx_bit_valid = 1'b0; rx_bit_zero = 1'b0; mos_nibble = 4'hA;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        rdchk(ADDR_MASK1, MASK_RESET, "mask1_reset");
        rdchk(ADDR_MASK2, MASK_RESET, "mask2_reset");
        // One enable bit at a time, walked over both masks
        for (int i = 0; i < 16; i++) begin
            wr((i < 8) ? ADDR_MASK1 : ADDR_MASK2, 8'h01 << (i % 8));
            rdchk((i < 8) ? ADDR_MASK1 : ADDR_MASK2, 8'h01 << (i % 8), "mask_rb");
            {status2_flags, status1_flags} = 16'h0001 << i;
            repeat (2) @(negedge clk_sys);
            chk("irq_on", {15'h0000, irq}, 16'h0001);
            {status2_flags, status1_flags} = ~(16'h0001 << i);
            repeat (2) @(negedge clk_sys);
            chk("irq_off", {15'h0000, irq}, 16'h0000);
            wr((i < 8) ? ADDR_MASK1 : ADDR_MASK2, 8'h00);
            rdchk((i < 8) ? ADDR_MASK1 : ADDR_MASK2, 8'h00, "mask_clr");
        end
        {status2_flags, status1_flags} = 16'h0000;
        wr(ADDR_LINE_HI, 8'hFF);
        rdchk(ADDR_LINE_HI, 8'h00, "line_hi_ro");
        rdchk(8'h30, READ_UNMAPPED, "unmapped");
        // Plain coding, ESF: codeword flag ignored, F-bit errors ignored
        mode(4'b0011);
        ev(5'b10000); ev(5'b10000); ev(5'b11000);
        bits(17, 1'b1); bits(1, 1'b0);
        ev(5'b00100); ev(5'b00100); ev(5'b00011);
        counts(16'h0004, 12'h002, SHORT_C);
        // Substitution on, no zero-run count; D4 without Fs
        mode(4'b1000);
        ev(5'b11000); ev(5'b10000);
        bits(20, 1'b1); bits(1, 1'b0);
        ev(5'b00010); ev(5'b00001); ev(5'b00010);
        counts(16'h0001, 12'h002, SHORT_C);
        // Substitution and zero-run count; D4 with Fs, both in one cycle
        mode(4'b1101);
        bits(7, 1'b1); bits(1, 1'b0); bits(9, 1'b1); bits(1, 1'b0);
        ev(5'b10000); ev(5'b00011);
        counts(16'h0002, 12'h002, SHORT_C);
        // Zero-run count without substitution, partly out of sync
        mode(4'b0110);
        rx_sync_lost = 1'b1;
        bits(16, 1'b1); bits(1, 1'b0);
        ev(5'b10000); ev(5'b00100);
        rx_sync_lost = 1'b0;
        ev(5'b00100);
        counts(16'h0002, 12'h001, SHORT_C);
        // Long interval, path pushed past its ceiling
        interval_select = 1'b0;
        mode(4'b0001);
        repeat (2100) ev(5'b10011);
        counts(16'h0834, 12'hFFF, LONG_C);
        wrap_up();
    end
endmodule

// ===== viol_cnt_if.sv
// Carrier between the performance top and one saturating violation counter.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps

interface viol_cnt_if #(
    parameter int W = 16
);
    logic [1:0]   amt;
    logic         boundary;
    logic [W-1:0] count;
    logic [W-1:0] latched;

    modport counter (input amt, input boundary, output count, output latched);
    modport user    (output amt, output boundary, input count, input latched);
endinterface

// ===== viol_counter.sv
// Saturating interval counter with a latched copy for software.
// Assumes amt and boundary are synchronous to clk_sys.
`timescale 1ns/1ps

module viol_counter
    import perf_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic   clk_sys,
    input  wire logic   arst_n,
    viol_cnt_if.counter cnt
);
    localparam logic [W-1:0] MAX = {W{1'b1}};

    logic [W:0] sum;

    if (W < 2 || W > 24) begin : g_check
        $error("viol_counter width out of range");
    end

    assign sum = {1'b0, cnt.count} + {{(W-1){1'b0}}, cnt.amt};

    // ----------------------------------------------------------------
    // Running count: restarts at each boundary, never wraps
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt.count <= '0;
        end else if (cnt.boundary) begin
            cnt.count <= {{(W-2){1'b0}}, cnt.amt};
        end else if (sum[W]) begin
            cnt.count <= MAX;
        end else begin
            cnt.count <= sum[W-1:0];
        end
    end

    // Latched copy only moves at a boundary, so reads stay coherent
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt.latched <= '0;
        end else if (cnt.boundary) begin
            cnt.latched <= cnt.count;
        end
    end
endmodule
